// file: hdl/utst_device.sv
`timescale 1ns/1ps
module utst_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to the host
  utst_link_if.devEnd link,
  // local logic program access to the table
  input wire logic [12:0] locAddr,
  input wire logic locWr,
  input wire logic [7:0] locWdata,
  output logic [7:0] locRdata,
  // state seen by the module
  output logic busy,
  output logic [15:0] lastStatus
);

  typedef struct packed {
    utst_pkg::utst_dev_state_t state;
    logic [9:0] cnt;
    logic [15:0] hdrLen;
    logic [15:0] sType;
    logic [15:0] cmd;
    logic [15:0] size;
    logic [15:0] dType;
    logic [15:0] dhData;
    logic dhValid;
    logic dhGo;
    logic dhStatus;
    logic present;
    logic busy;
    logic [15:0] lastStatus;
    logic [7:0] locRdata;
  } utst_dev_regs_t;

  utst_dev_regs_t st_r;
  utst_dev_regs_t st_nxt;

  logic [7:0] tableMem [0:utst_pkg::TABLE_BYTES-1];
  logic tblWe;
  logic [11:0] tblWord;
  logic [1:0] seg;
  logic cmdOk;
  logic sTypeOk;
  logic dTypeOk;
  logic [15:0] verdict;

  // segment and direction come straight from the command code
  assign seg = st_r.cmd[utst_pkg::CMD_SEG_LSB +: 2];
  assign tblWord = {seg, st_r.cnt};

  // only the eight table codes pass; the parameter load code falls out here
  always_comb
  begin
    cmdOk = ((st_r.cmd & ~utst_pkg::CMD_SEG_MASK) == utst_pkg::CMD_WR_BASE) ||
            ((st_r.cmd & ~utst_pkg::CMD_SEG_MASK) == utst_pkg::CMD_RD_BASE);
  end

  // memory type checks for the status word and the data area
  always_comb
  begin
    sTypeOk = (st_r.sType == utst_pkg::MT_DISC_IN) ||
              (st_r.sType == utst_pkg::MT_DISC_OUT) ||
              (st_r.sType == utst_pkg::MT_REG) ||
              (st_r.sType == utst_pkg::MT_AIN) ||
              (st_r.sType == utst_pkg::MT_AOUT);
    dTypeOk = (st_r.dType == utst_pkg::MT_REG) ||
              (st_r.dType == utst_pkg::MT_AIN) ||
              (st_r.dType == utst_pkg::MT_AOUT);
  end

  // first failing check decides the error code
  always_comb
  begin
    if (st_r.hdrLen != utst_pkg::HDR_LEN)
    begin
      verdict = utst_pkg::ST_ERR_HDR;
    end
    else if (!cmdOk)
    begin
      verdict = utst_pkg::ST_ERR_CMD;
    end
    else if (st_r.size != utst_pkg::SEG_SIZE)
    begin
      verdict = utst_pkg::ST_ERR_SIZE;
    end
    else if (!sTypeOk || !dTypeOk)
    begin
      verdict = utst_pkg::ST_ERR_TYPE;
    end
    else
    begin
      verdict = utst_pkg::ST_OK;
    end
  end

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dhValid = 1'b0;
    st_nxt.dhGo = 1'b0;
    st_nxt.dhStatus = 1'b0;
    st_nxt.present = 1'b1;
    st_nxt.locRdata = tableMem[locAddr];
    tblWe = 1'b0;
    unique case (st_r.state)
      utst_pkg::DEV_IDLE:
      begin
        // a request always opens with its header length word
        if (link.hdValid)
        begin
          st_nxt.hdrLen = link.hdData;
          st_nxt.cnt = 10'h001;
          st_nxt.busy = 1'b1;
          st_nxt.state = utst_pkg::DEV_HDR;
        end
      end
      utst_pkg::DEV_HDR:
      begin
        if (link.hdValid)
        begin
          // wait flag, timeouts and host offsets are not needed here
          unique case (st_r.cnt[3:0])
            utst_pkg::W_STYPE: st_nxt.sType = link.hdData;
            utst_pkg::W_CMD: st_nxt.cmd = link.hdData;
            utst_pkg::W_SIZE: st_nxt.size = link.hdData;
            utst_pkg::W_DTYPE: st_nxt.dType = link.hdData;
            default: st_nxt.cnt = st_nxt.cnt;
          endcase
          if (st_r.cnt == utst_pkg::CNT_LAST_HDR)
          begin
            st_nxt.cnt = 10'h000;
            st_nxt.state = utst_pkg::DEV_CHECK;
          end
          else
          begin
            st_nxt.cnt = st_r.cnt + 10'h001;
          end
        end
      end
      utst_pkg::DEV_CHECK:
      begin
        if (verdict != utst_pkg::ST_OK)
        begin
          // refused: no data moves, the error goes straight back
          st_nxt.dhStatus = 1'b1;
          st_nxt.dhData = verdict;
          st_nxt.lastStatus = verdict;
          st_nxt.busy = 1'b0;
          st_nxt.state = utst_pkg::DEV_IDLE;
        end
        else
        begin
          st_nxt.dhGo = 1'b1;
          if (st_r.cmd[utst_pkg::CMD_READ_BIT])
          begin
            st_nxt.state = utst_pkg::DEV_READ;
          end
          else
          begin
            st_nxt.state = utst_pkg::DEV_WRITE;
          end
        end
      end
      utst_pkg::DEV_WRITE:
      begin
        // host may leave gaps between words, so count only valid ones
        if (link.hdValid)
        begin
          tblWe = 1'b1;
          if (st_r.cnt == utst_pkg::CNT_LAST_DATA)
          begin
            st_nxt.cnt = 10'h000;
            st_nxt.state = utst_pkg::DEV_STAT;
          end
          else
          begin
            st_nxt.cnt = st_r.cnt + 10'h001;
          end
        end
      end
      utst_pkg::DEV_READ:
      begin
        // low byte at the even table address
        st_nxt.dhValid = 1'b1;
        st_nxt.dhData = {tableMem[{tblWord, 1'b1}], tableMem[{tblWord, 1'b0}]};
        if (st_r.cnt == utst_pkg::CNT_LAST_DATA)
        begin
          st_nxt.cnt = 10'h000;
          st_nxt.state = utst_pkg::DEV_STAT;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt + 10'h001;
        end
      end
      utst_pkg::DEV_STAT:
      begin
        // one 16-bit word; the host spreads it over bits when discrete
        st_nxt.dhStatus = 1'b1;
        st_nxt.dhData = utst_pkg::ST_OK;
        st_nxt.lastStatus = utst_pkg::ST_OK;
        st_nxt.busy = 1'b0;
        st_nxt.state = utst_pkg::DEV_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // table writes; the link wins, so a local write in the same cycle is lost
  always_ff @(posedge ref_clk)
  begin
    if (tblWe)
    begin
      tableMem[{tblWord, 1'b0}] <= link.hdData[7:0];
      tableMem[{tblWord, 1'b1}] <= link.hdData[15:8];
    end
    else if (locWr)
    begin
      tableMem[locAddr] <= locWdata;
    end
  end

  // outputs straight from flops
  assign link.dhValid = st_r.dhValid;
  assign link.dhData = st_r.dhData;
  assign link.dhGo = st_r.dhGo;
  assign link.dhStatus = st_r.dhStatus;
  assign link.devPresent = st_r.present;
  assign locRdata = st_r.locRdata;
  assign busy = st_r.busy;
  assign lastStatus = st_r.lastStatus;

endmodule

// file: hdl/utst_host.sv
`timescale 1ns/1ps
module utst_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link to the device
  utst_link_if.hostEnd link,
  // software register port
  input wire logic [15:0] swAddr,
  input wire logic [15:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [15:0] swRdata,
  // request state
  output logic busy,
  output logic faultOut
);

  typedef struct packed {
    utst_pkg::utst_host_state_t state;
    logic [9:0] cnt;
    logic gap;
    logic window;
    logic [15:0] cmd;
    logic [15:0] sType;
    logic [15:0] sOff;
    logic [15:0] dType;
    logic [15:0] dOff;
    logic [15:0] taskNum;
    logic fault;
    logic done;
    logic busy;
    logic [15:0] lastStatus;
    logic hdValid;
    logic [15:0] hdData;
    logic [15:0] swRdata;
  } utst_host_regs_t;

  utst_host_regs_t st_r;
  utst_host_regs_t st_nxt;

  // word areas: register, analog in, analog out; bit areas: inputs, outputs
  logic [15:0] wordMem [0:16383];
  logic bitMem [0:8191];
  logic memWe;
  logic [13:0] memAddr;
  logic [15:0] memWdata;
  logic stBitWe;
  logic swBitWe;
  logic regSel;
  logic [13:0] dataAddr;

  function automatic logic [1:0] areaOf(input logic [15:0] t);
    if (t == utst_pkg::MT_REG) return 2'h0;
    if (t == utst_pkg::MT_AIN) return 2'h1;
    if (t == utst_pkg::MT_AOUT) return 2'h2;
    return 2'h3;
  endfunction

  // zero-based offset; wraps inside a 4096-word area
  assign dataAddr = {areaOf(st_r.dType), st_r.dOff[11:0] + {2'h0, st_r.cnt}};
  assign regSel = !swAddr[utst_pkg::SEL_WORD_MEM] && !swAddr[utst_pkg::SEL_BIT_MEM];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.hdValid = 1'b0;
    st_nxt.swRdata = 16'h0000;
    memWe = 1'b0;
    memAddr = swAddr[13:0];
    memWdata = swWdata;
    stBitWe = 1'b0;
    swBitWe = swWr && swAddr[utst_pkg::SEL_BIT_MEM];
    // software reads answer in the next cycle
    if (swRd)
    begin
      if (swAddr[utst_pkg::SEL_WORD_MEM])
        st_nxt.swRdata = wordMem[swAddr[13:0]];
      else if (swAddr[utst_pkg::SEL_BIT_MEM])
        st_nxt.swRdata = {15'h0000, bitMem[swAddr[12:0]]};
      else
        unique case (swAddr)
          utst_pkg::A_STATUS: st_nxt.swRdata = {13'h0000, st_r.done, st_r.fault, st_r.busy};
          utst_pkg::A_CMD: st_nxt.swRdata = st_r.cmd;
          utst_pkg::A_STYPE: st_nxt.swRdata = st_r.sType;
          utst_pkg::A_SOFF: st_nxt.swRdata = st_r.sOff;
          utst_pkg::A_DTYPE: st_nxt.swRdata = st_r.dType;
          utst_pkg::A_DOFF: st_nxt.swRdata = st_r.dOff;
          utst_pkg::A_TASK: st_nxt.swRdata = st_r.taskNum;
          utst_pkg::A_LAST: st_nxt.swRdata = st_r.lastStatus;
          default: st_nxt.swRdata = {15'h0000, st_r.window};
        endcase
    end
    if (swWr && swAddr[utst_pkg::SEL_WORD_MEM])
      memWe = 1'b1;
    // request fields are frozen while a request runs
    if (swWr && regSel && st_r.state == utst_pkg::HOST_IDLE)
    begin
      unique case (swAddr)
        utst_pkg::A_CTRL: st_nxt.window = swWdata[utst_pkg::CTRL_WINDOW];
        utst_pkg::A_CMD: st_nxt.cmd = swWdata;
        utst_pkg::A_STYPE: st_nxt.sType = swWdata;
        utst_pkg::A_SOFF: st_nxt.sOff = swWdata;
        utst_pkg::A_DTYPE: st_nxt.dType = swWdata;
        utst_pkg::A_DOFF: st_nxt.dOff = swWdata;
        utst_pkg::A_TASK: st_nxt.taskNum = swWdata;
        default: st_nxt.done = st_r.done;
      endcase
    end
    unique case (st_r.state)
      utst_pkg::HOST_IDLE:
      begin
        if (swWr && swAddr == utst_pkg::A_CTRL && swWdata[utst_pkg::CTRL_START])
        begin
          st_nxt.done = 1'b0;
          st_nxt.cnt = 10'h000;
          st_nxt.fault = (st_r.taskNum != 16'h0000) || !link.devPresent;
          if (st_nxt.fault == 1'b0)
          begin
            st_nxt.busy = 1'b1;
            st_nxt.state = utst_pkg::HOST_SEND;
          end
        end
      end
      utst_pkg::HOST_SEND:
      begin
        st_nxt.hdValid = 1'b1;
        unique case (st_r.cnt[3:0])
          utst_pkg::W_HDRLEN: st_nxt.hdData = utst_pkg::HDR_LEN;
          utst_pkg::W_WAIT: st_nxt.hdData = utst_pkg::WAIT_FLAG;
          utst_pkg::W_STYPE: st_nxt.hdData = st_r.sType;
          utst_pkg::W_SOFF: st_nxt.hdData = st_r.sOff;
          utst_pkg::W_IDLE: st_nxt.hdData = utst_pkg::UNUSED_TIME;
          utst_pkg::W_MAXT: st_nxt.hdData = utst_pkg::UNUSED_TIME;
          utst_pkg::W_CMD: st_nxt.hdData = st_r.cmd;
          utst_pkg::W_SIZE: st_nxt.hdData = utst_pkg::SEG_SIZE;
          utst_pkg::W_DTYPE: st_nxt.hdData = st_r.dType;
          default: st_nxt.hdData = st_r.dOff;
        endcase
        st_nxt.cnt = st_r.cnt + 10'h001;
        if (st_r.cnt == utst_pkg::CNT_LAST_HDR)
        begin
          st_nxt.cnt = 10'h000;
          st_nxt.state = utst_pkg::HOST_WAITGO;
        end
      end
      utst_pkg::HOST_WAITGO:
      begin
        st_nxt.gap = 1'b0;
        if (link.dhGo)
          st_nxt.state = st_r.cmd[utst_pkg::CMD_READ_BIT] ? utst_pkg::HOST_WAITST
                                                          : utst_pkg::HOST_XMIT;
      end
      utst_pkg::HOST_XMIT:
      begin
        // window mode leaves a one-cycle hole after each word
        if (st_r.window && st_r.gap)
          st_nxt.gap = 1'b0;
        else
        begin
          st_nxt.hdValid = 1'b1;
          st_nxt.hdData = wordMem[dataAddr];
          st_nxt.gap = st_r.window;
          st_nxt.cnt = st_r.cnt + 10'h001;
          if (st_r.cnt == utst_pkg::CNT_LAST_DATA)
            st_nxt.state = utst_pkg::HOST_WAITST;
        end
      end
      utst_pkg::HOST_WAITST:
      begin
        if (link.dhValid)
        begin
          memWe = 1'b1;
          memAddr = dataAddr;
          memWdata = link.dhData;
          st_nxt.cnt = st_r.cnt + 10'h001;
        end
      end
    endcase
    // outcome lands at the status location whatever the verdict; an unknown status type stores it nowhere
    if (link.dhStatus && st_r.busy)
    begin
      st_nxt.lastStatus = link.dhData;
      st_nxt.done = 1'b1;
      st_nxt.busy = 1'b0;
      st_nxt.state = utst_pkg::HOST_IDLE;
      if (st_r.sType == utst_pkg::MT_DISC_IN || st_r.sType == utst_pkg::MT_DISC_OUT)
        stBitWe = 1'b1;
      else if (areaOf(st_r.sType) != 2'h3)
      begin
        memWe = 1'b1;
        memAddr = {areaOf(st_r.sType), st_r.sOff[11:0]};
        memWdata = link.dhData;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // host memory; a status spread over bits outranks a software bit write
  always_ff @(posedge ref_clk)
  begin
    if (memWe)
      wordMem[memAddr] <= memWdata;
    if (stBitWe)
      for (int i = 0; i < 16; i++)
        bitMem[{st_r.sType == utst_pkg::MT_DISC_OUT, 12'(st_r.sOff[11:0] + 12'(i))}]
          <= link.dhData[i];
    else if (swBitWe)
      bitMem[swAddr[12:0]] <= swWdata[0];
  end

  assign link.hdValid = st_r.hdValid;
  assign link.hdData = st_r.hdData;
  assign swRdata = st_r.swRdata;
  assign busy = st_r.busy;
  assign faultOut = st_r.fault;

endmodule

// file: hdl/utst_link_if.sv
`timescale 1ns/1ps
interface utst_link_if;
  // host to device word channel
  logic hdValid;
  logic [15:0] hdData;
  // device to host word channel and markers
  logic dhValid;
  logic [15:0] dhData;
  logic dhGo;
  logic dhStatus;
  logic devPresent;

  modport devEnd(input hdValid, hdData, output dhValid, dhData, dhGo, dhStatus, devPresent);
  modport hostEnd(output hdValid, hdData, input dhValid, dhData, dhGo, dhStatus, devPresent);
endinterface

// file: hdl/utst_pkg.sv
// Summary of operation
// - 8192-byte table as four 2048-byte segments
// - every transfer moves exactly 2048 bytes
// - codes d001..d301 write segments one to four
// - codes d804..db04 read segments one to four
// - host sets header length word to 4
// - host sets wait-mode flag word to zero
// - timeout words are zero and ignored
// - memory type codes 46h 48h 08h 0ah 0ch
// - discrete status takes sixteen consecutive bits
// - status offset is zero-based
// - host sets size word to 800h
// - data area only 08h, 0ah or 0ch
// - data offset starts 1024 contiguous host words
// - command, size, type, offset at words 6..9
// - each host word carries two table bytes
// - parameter load code is not accepted here
// - host may spread request over scans
// - host flags activity to avoid access conflicts
// - outcome reported into the status word unless its type is unknown
// - host faults on absent target or task
package utst_pkg;

  // table geometry
  localparam int TABLE_BYTES = 8192;
  localparam int SEG_WORDS = 1024;
  localparam logic [9:0] CNT_LAST_DATA = 10'h3ff;
  localparam logic [9:0] CNT_LAST_HDR = 10'h009;

  // request block word offsets
  localparam logic [3:0] W_HDRLEN = 4'h0;
  localparam logic [3:0] W_WAIT = 4'h1;
  localparam logic [3:0] W_STYPE = 4'h2;
  localparam logic [3:0] W_SOFF = 4'h3;
  localparam logic [3:0] W_IDLE = 4'h4;
  localparam logic [3:0] W_MAXT = 4'h5;
  localparam logic [3:0] W_CMD = 4'h6;
  localparam logic [3:0] W_SIZE = 4'h7;
  localparam logic [3:0] W_DTYPE = 4'h8;
  localparam logic [3:0] W_DOFF = 4'h9;

  // fixed request word values
  localparam logic [15:0] HDR_LEN = 16'h0004;
  localparam logic [15:0] WAIT_FLAG = 16'h0000;
  localparam logic [15:0] UNUSED_TIME = 16'h0000;
  localparam logic [15:0] SEG_SIZE = 16'h0800;

  // command codes: segment in bits 9:8, direction in bit 11
  localparam logic [15:0] CMD_WR_BASE = 16'hd001;
  localparam logic [15:0] CMD_RD_BASE = 16'hd804;
  localparam logic [15:0] CMD_SEG_MASK = 16'h0300;
  localparam int CMD_SEG_LSB = 8;
  localparam int CMD_READ_BIT = 11;

  // memory type codes
  localparam logic [15:0] MT_DISC_IN = 16'h0046;
  localparam logic [15:0] MT_DISC_OUT = 16'h0048;
  localparam logic [15:0] MT_REG = 16'h0008;
  localparam logic [15:0] MT_AIN = 16'h000a;
  localparam logic [15:0] MT_AOUT = 16'h000c;

  // outcome codes
  localparam logic [15:0] ST_OK = 16'h0001;
  localparam logic [15:0] ST_ERR_CMD = 16'h0002;
  localparam logic [15:0] ST_ERR_SIZE = 16'h0003;
  localparam logic [15:0] ST_ERR_TYPE = 16'h0004;
  localparam logic [15:0] ST_ERR_HDR = 16'h0005;

  // host register map
  localparam logic [15:0] A_CTRL = 16'h0000;
  localparam logic [15:0] A_STATUS = 16'h0001;
  localparam logic [15:0] A_CMD = 16'h0002;
  localparam logic [15:0] A_STYPE = 16'h0003;
  localparam logic [15:0] A_SOFF = 16'h0004;
  localparam logic [15:0] A_DTYPE = 16'h0005;
  localparam logic [15:0] A_DOFF = 16'h0006;
  localparam logic [15:0] A_TASK = 16'h0007;
  localparam logic [15:0] A_LAST = 16'h0008;
  localparam int SEL_WORD_MEM = 15;
  localparam int SEL_BIT_MEM = 14;
  localparam int CTRL_START = 0;
  localparam int CTRL_WINDOW = 1;

  typedef enum logic [2:0] {DEV_IDLE, DEV_HDR, DEV_CHECK, DEV_WRITE, DEV_READ, DEV_STAT}
    utst_dev_state_t;
  typedef enum logic [2:0] {HOST_IDLE, HOST_SEND, HOST_WAITGO, HOST_XMIT, HOST_WAITST}
    utst_host_state_t;

endpackage

// file: verif/user_table_segment_transfer_tb_top.sv
`timescale 1ns/1ps
module user_table_segment_transfer_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] swAddr = 16'h0000;
  logic [15:0] swWdata = 16'h0000;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic [12:0] locAddr = 13'h0000;
  logic locWr = 1'b0;
  logic [7:0] locWdata = 8'h00;
  logic [15:0] swRdata, lastStatus, v;
  logic [7:0] locRdata;
  logic hBusy, faultOut, dBusy;
  int bad_count = 0;
  int n_compared = 0;
  // refused requests: command, status type, status offset, data type, outcome
  logic [15:0] eCmd [4] = '{16'he501, 16'hd002, 16'hd001, 16'hdb04};
  logic [15:0] eSt [4] = '{16'h0048, 16'h0046, 16'h0008, 16'h000b};
  logic [15:0] eSo [4] = '{16'h0003, 16'h0020, 16'h0009, 16'h0000};
  logic [15:0] eDt [4] = '{16'h0008, 16'h0008, 16'h0046, 16'h000a};
  logic [15:0] eExp [4] = '{16'h0002, 16'h0002, 16'h0004, 16'h0004};

  always #5 ref_clk = ~ref_clk;

  utst_link_if link ();
  utst_host i_utst_host (.ref_clk(ref_clk), .rst(rst), .link(link), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .busy(hBusy),
    .faultOut(faultOut));
  utst_device i_utst_device (.ref_clk(ref_clk), .rst(rst), .link(link), .locAddr(locAddr),
    .locWr(locWr), .locWdata(locWdata), .locRdata(locRdata), .busy(dBusy),
    .lastStatus(lastStatus));
  utst_link_sva i_utst_link_sva (.ref_clk(ref_clk), .rst(rst), .hdValid(link.hdValid),
    .hdData(link.hdData), .dhValid(link.dhValid), .dhData(link.dhData), .dhGo(link.dhGo),
    .dhStatus(link.dhStatus), .devPresent(link.devPresent));

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic ck(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge ref_clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge ref_clk);
    swWr <= 1'b0;
  endtask

  task automatic rd(logic [15:0] a);
    @(posedge ref_clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge ref_clk);
    swRd <= 1'b0;
    #1;
    v = swRdata;
  endtask

  task automatic llrd(logic [12:0] a);
    @(posedge ref_clk);
    locAddr <= a;
    @(posedge ref_clk);
    #1;
    v = {8'h00, locRdata};
  endtask

  function automatic logic [15:0] pat(int s, int n);
    return {s[1:0], 4'ha, n[9:0]};
  endfunction

  function automatic logic [15:0] wa(logic [1:0] ar, logic [11:0] off);
    return {2'b10, ar, off};
  endfunction

  // program a request, start it, then wait for the host to go idle
  task automatic run(logic [15:0] cmd, logic [15:0] st, logic [15:0] so, logic [15:0] dt,
    logic [15:0] tsk, logic [15:0] ctl);
    int i;
    wr(utst_pkg::A_CMD, cmd);
    wr(utst_pkg::A_STYPE, st);
    wr(utst_pkg::A_SOFF, so);
    wr(utst_pkg::A_DTYPE, dt);
    wr(utst_pkg::A_DOFF, 16'h0100);
    wr(utst_pkg::A_TASK, tsk);
    wr(utst_pkg::A_CTRL, ctl);
    repeat (3) @(posedge ref_clk);
    for (i = 0; hBusy !== 1'b0 && i < 3000; i++)
      @(posedge ref_clk);
    if (i == 3000)
    begin
      bad_count++;
      $display("unexpected host busy: expected 0 seen %b", hBusy);
      end_of_test();
    end
    ck("device busy", 16'h0000, {15'h0000, dBusy});
  endtask

  initial
  begin
    int s;
    int n;
    logic [15:0] e;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(utst_pkg::A_STATUS);
    ck("status after reset", 16'h0000, v);
    $display("test reset done");
    // nonzero task number faults and sends nothing
    run(16'hd001, 16'h0008, 16'h0000, 16'h0008, 16'h0001, 16'h0001);
    ck("fault output", 16'h0001, {15'h0000, faultOut});
    ck("device outcome", 16'h0000, lastStatus);
    $display("test task fault done");
    // write every segment; the third runs in window mode
    for (s = 0; s < 4; s++)
    begin
      for (n = 0; n < 1024; n++)
        wr(wa(2'd0, 12'h100 + n[11:0]), pat(s, n));
      run(16'hd001 | 16'(s << 8), 16'h0008, 16'(s), 16'h0008, 16'h0000,
        (s == 2) ? 16'h0003 : 16'h0001);
      rd(wa(2'd0, s[11:0]));
      ck("status word", 16'h0001, v);
      rd(utst_pkg::A_STATUS);
      ck("host status", 16'h0004, v);
      rd(utst_pkg::A_CTRL);
      ck("window bit", {15'h0000, s == 2}, v);
      for (n = 0; n < 1024; n += 1023)
      begin
        llrd({s[1:0], n[9:0], 1'b0});
        ck("table low byte", pat(s, n) & 16'h00ff, v);
        llrd({s[1:0], n[9:0], 1'b1});
        ck("table high byte", pat(s, n) >> 8, v);
      end
    end
    $display("test segment writes done");
    // local program alters one byte of segment four before it is read back
    @(posedge ref_clk);
    locAddr <= {2'd3, 10'd7, 1'b1};
    locWdata <= 8'h5a;
    locWr <= 1'b1;
    @(posedge ref_clk);
    locWr <= 1'b0;
    for (s = 0; s < 4; s++)
    begin
      e = (s == 0) ? 16'h0008 : ((s == 1) ? 16'h000a : 16'h000c);
      run(16'hd804 | 16'(s << 8), 16'h000a, 16'h0800 + 16'(s), e, 16'h0000, 16'h0001);
      rd(wa(2'd1, 12'h800 + s[11:0]));
      ck("read outcome", 16'h0001, v);
      for (n = 0; n < 1024; n++)
      begin
        rd(wa(e[2:1], 12'h100 + n[11:0]));
        ck("host word", (s == 3 && n == 7) ? 16'h5a00 | pat(s, n) & 16'h00ff : pat(s, n),
          v);
      end
    end
    $display("test segment reads done");
    for (s = 0; s < 4; s++)
    begin
      run(eCmd[s], eSt[s], eSo[s], eDt[s], 16'h0000, 16'h0001);
      rd(utst_pkg::A_LAST);
      ck("last outcome", eExp[s], v);
      ck("device outcome", eExp[s], lastStatus);
      for (n = 0; n < 16 && s < 2; n++)
      begin
        rd({3'b010, s == 0, eSo[s][11:0] + n[11:0]});
        ck("status bit", {15'h0000, eExp[s][n]}, v);
      end
    end
    rd(wa(2'd0, 12'h009));
    ck("status word", 16'h0004, v);
    llrd(13'h0000);
    ck("untouched byte", pat(0, 0) & 16'h00ff, v);
    $display("test refusals done");
    end_of_test();
  end
endmodule

// file: verif/utst_link_sva.sv
`timescale 1ns/1ps
module utst_link_sva (
  // clock and reset
  input logic ref_clk,
  input logic rst,
  // link signals
  input logic hdValid,
  input logic [15:0] hdData,
  input logic dhValid,
  input logic [15:0] dhData,
  input logic dhGo,
  input logic dhStatus,
  input logic devPresent
);
  logic inData_r;
  logic [10:0] hdrCnt_r;
  logic [10:0] datCnt_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // phase tracking; counts restart at every answer so a lost word cannot hide
  always_ff @(posedge ref_clk)
  begin
    if (rst || dhStatus)
    begin
      inData_r <= 1'b0;
      hdrCnt_r <= 11'h000;
      datCnt_r <= 11'h000;
    end
    else if (dhGo)
    begin
      inData_r <= 1'b1;
      hdrCnt_r <= 11'h000;
    end
    else if (!inData_r && hdValid)
      hdrCnt_r <= hdrCnt_r + 11'h001;
    else if (inData_r && (hdValid || dhValid))
      datCnt_r <= datCnt_r + 11'h001;
  end

  chk_present_after_rst: assert property ($fell(rst) |-> !devPresent ##1 devPresent)
    else $error("device presence wrong after reset");
  chk_hdr_len_word: assert property (
    hdValid && !inData_r && hdrCnt_r == 11'h000 |-> hdData == 16'h0004)
    else $error("header length word wrong");
  chk_wait_flag_zero: assert property (
    hdValid && !inData_r && hdrCnt_r == 11'h001 |-> hdData == 16'h0000)
    else $error("wait flag word not zero");
  chk_idle_words_zero: assert property (
    hdValid && !inData_r && hdrCnt_r inside {11'h004, 11'h005} |-> hdData == 16'h0000)
    else $error("timeout word not zero");
  chk_size_word: assert property (
    hdValid && !inData_r && hdrCnt_r == 11'h007 |-> hdData == 16'h0800)
    else $error("size word not 800h");
  chk_answer_delay: assert property (
    hdValid && !inData_r && hdrCnt_r == 11'h009 |-> ##2 (dhGo ^ dhStatus))
    else $error("no answer two cycles after header");
  chk_hdr_ten_words: assert property (
    (dhGo || dhStatus) && !inData_r |-> hdrCnt_r == 11'h00a)
    else $error("header not ten words");
  chk_data_count: assert property (
    dhStatus && inData_r |-> datCnt_r == 11'h400 && dhData == 16'h0001)
    else $error("data phase not 1024 words or bad outcome");
  chk_err_outcome: assert property (
    dhStatus && !inData_r |-> dhData inside {16'h0002, 16'h0003, 16'h0004, 16'h0005})
    else $error("refused request without error code");
  chk_read_one_way: assert property (dhValid |-> !hdValid && inData_r)
    else $error("read data outside data phase");
  chk_go_pulse: assert property (dhGo |=> !dhGo && !dhStatus)
    else $error("go not a single pulse");
endmodule
